// ### logic/tx_buffer_config.sv
/*
  Transmit buffer configuration register with its own control bits
  (init, config-change enable) and the derived section layout.
  Assumes an APB master on core_clk; element size is WORDS_PER_BUFFER words per slot.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps
module tx_buffer_config
  import tx_buffer_config_pkg::*;
#(
  parameter int WORDS_PER_BUFFER = 4
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire apb_req_t apb_req, // apb request
  output apb_rsp_t apb_rsp, // apb answer
  output tx_layout_t layout, // effective configuration
  output logic init_active, // init bit
  output logic config_change_enable // cce bit
);

  // refuse slot sizes the layout arithmetic cannot serve
  if (WORDS_PER_BUFFER < 1 || WORDS_PER_BUFFER > 18) begin : g_bad_wpb
    $error("WORDS_PER_BUFFER out of range");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] can_tx_buffer_configuration_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic wr_txbc, wr_ctrl, access, unmapped;

  assign access = apb_req.psel && apb_req.penable;
  assign wr_txbc = access && apb_req.pwrite && (apb_req.paddr == TXBC_ADDR)
    && ctrl_reg[CCE_BIT] && ctrl_reg[INIT_BIT];
  assign wr_ctrl = access && apb_req.pwrite && (apb_req.paddr == CTRL_ADDR);
  assign unmapped = (apb_req.paddr != TXBC_ADDR) && (apb_req.paddr != CTRL_ADDR);

  // no range check of combined counts, no error flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      can_tx_buffer_configuration_reg <= TXBC_RESET;
    end else if (wr_txbc) begin
      can_tx_buffer_configuration_reg <= apb_req.pwdata & TXBC_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {apb_req.pwdata[CCE_BIT], apb_req.pwdata[INIT_BIT]};
    end
  end

  // read data registered in setup so it is ready in access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      if (apb_req.paddr == TXBC_ADDR) begin
        rdata_reg <= can_tx_buffer_configuration_reg;
      end else if (apb_req.paddr == CTRL_ADDR) begin
        rdata_reg <= {30'h0, ctrl_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    apb_rsp.prdata = rdata_reg;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = access && unmapped;
  end

  // ----------------------------------------
  // effective layout
  // ----------------------------------------
  logic [5:0] raw_count, raw_size, count_eff, size_eff;
  logic [13:0] start_word;
  logic [19:0] first_fifo_word;

  assign raw_count = can_tx_buffer_configuration_reg[COUNT_MSB:COUNT_LSB];
  assign raw_size = can_tx_buffer_configuration_reg[SIZE_MSB:SIZE_LSB];
  assign count_eff = (raw_count > MAX_BUFFERS) ? MAX_BUFFERS : raw_count;
  assign size_eff = (raw_size > MAX_BUFFERS) ? MAX_BUFFERS : raw_size;
  assign start_word = can_tx_buffer_configuration_reg[START_MSB:START_LSB];
  assign first_fifo_word = 20'(start_word) + 20'(count_eff) * 20'(WORDS_PER_BUFFER);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      layout <= '0;
    end else begin
      layout.tx_section_start_word <= start_word;
      layout.dedicated_tx_count <= count_eff;
      layout.tx_fifo_queue_size <= size_eff;
      layout.tx_fifo_queue_select <= fifo_queue_mode_t'(
        can_tx_buffer_configuration_reg[MODE_BIT]);
      layout.fifo_queue_first_word <= first_fifo_word[13:0];
    end
  end

  assign init_active = ctrl_reg[INIT_BIT];
  assign config_change_enable = ctrl_reg[CCE_BIT];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_locked_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    (access && apb_req.pwrite && apb_req.paddr == TXBC_ADDR && !(ctrl_reg == 2'h3))
    |=> $stable(can_tx_buffer_configuration_reg))
    else $error("config changed while locked");
  a_open_write_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_txbc |=> can_tx_buffer_configuration_reg == ($past(apb_req.pwdata) & TXBC_MASK))
    else $error("unlocked write not stored");
  a_low_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    can_tx_buffer_configuration_reg[1:0] == 2'h0 && !can_tx_buffer_configuration_reg[31])
    else $error("reserved bits set");
  a_count_clamped: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 layout.dedicated_tx_count == (($past(raw_count) > 6'd32) ? 6'd32 : $past(raw_count)))
    else $error("count clamp wrong");
  a_size_clamped: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 layout.tx_fifo_queue_size == (($past(raw_size) > 6'd32) ? 6'd32 : $past(raw_size)))
    else $error("size clamp wrong");
  a_mode_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (layout.tx_fifo_queue_select == MODE_QUEUE)
      == $past(can_tx_buffer_configuration_reg[30]))
    else $error("mode wrong");
  a_start_word_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 layout.tx_section_start_word == $past(can_tx_buffer_configuration_reg[15:2]))
    else $error("start word wrong");
  a_fifo_after_ded: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 layout.fifo_queue_first_word == 14'($past(start_word)
      + 14'($past(count_eff)) * 14'(WORDS_PER_BUFFER)))
    else $error("fifo section misplaced");
  a_no_error_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
    (access && apb_req.paddr == TXBC_ADDR) |-> !apb_rsp.pslverr)
    else $error("error on config access");

  c_open_write: cover property (@(posedge core_clk) disable iff (!rst_n) wr_txbc);
  c_locked_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    access && apb_req.pwrite && apb_req.paddr == TXBC_ADDR && !wr_txbc);
  c_clamp_seen: cover property (@(posedge core_clk) disable iff (!rst_n) raw_count > 6'd32);
  c_queue_mode: cover property (@(posedge core_clk) disable iff (!rst_n)
    layout.tx_fifo_queue_select == MODE_QUEUE);

endmodule

// ### logic/tx_buffer_config_pkg.sv
/*
  Constants, field layout and carrier types for the transmit buffer
  configuration register block.
  Assumes a 32-bit APB register bus and a single core clock.
*/
// Summary of operation
// - Writes to the configuration register are ignored unless both config-change and init are set.
// - The start field gives the word address of the transmit section in message RAM.
// - Dedicated count zero means none, 1 to 32 that many, and larger values act as 32.
// - FIFO/queue size zero means none, 1 to 32 that many, and larger values act as 32.
// - The mode bit selects FIFO operation when clear and queue operation when set.
// - An invalid combined count is accepted with no error indication.
// - Dedicated buffers come first in the section, FIFO/queue buffers follow them.
package tx_buffer_config_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] TXBC_ADDR = 32'hf805_40c0;
  localparam logic [31:0] CTRL_ADDR = 32'hf805_4100;
  localparam logic [31:0] TXBC_RESET = 32'h0000_0000;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MODE_BIT = 30;
  localparam int SIZE_LSB = 24;
  localparam int SIZE_MSB = 29;
  localparam int COUNT_LSB = 16;
  localparam int COUNT_MSB = 21;
  localparam int START_LSB = 2;
  localparam int START_MSB = 15;
  localparam int INIT_BIT = 0;
  localparam int CCE_BIT = 1;
  localparam logic [31:0] TXBC_MASK = 32'h7f3f_fffc;

  localparam logic [5:0] MAX_BUFFERS = 6'h20;

  typedef enum logic {
    MODE_FIFO,
    MODE_QUEUE
  } fifo_queue_mode_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [13:0] tx_section_start_word;
    logic [5:0] dedicated_tx_count;
    logic [5:0] tx_fifo_queue_size;
    fifo_queue_mode_t tx_fifo_queue_select;
    logic [13:0] fifo_queue_first_word;
  } tx_layout_t;

endpackage

// ### sim/apb_master.sv
/*
  APB master model that drives the configuration block's register bus.
  Assumes one core clock and a slave that answers through pready.
*/
`timescale 1ns/1ps
module apb_master
  import tx_buffer_config_pkg::*;
(
  input wire logic core_clk, // clock
  input wire apb_rsp_t apb_rsp, // answer
  output apb_req_t apb_req // request
);
  initial apb_req = '0;

  // -------------------------
  // one transfer
  // -------------------------
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r,
                      output logic err);
    @(posedge core_clk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
endmodule

// ### sim/can_tx_buffer_config_tb_top.sv
/*
  Self-checking bench for the transmit buffer configuration block.
  Assumes the APB master model and zero wait states are not relied on.
*/
`timescale 1ns/1ps
module can_tx_buffer_config_tb_top;
  import tx_buffer_config_pkg::*;
  localparam int WPB = 3;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  tx_layout_t layout;
  logic init_active, config_change_enable, err;
  logic [31:0] seed = 32'h0001_52f7;
  logic [31:0] m_txbc, m_ctrl, rd, d;
  int fail_count = 0;
  int num_checks = 0;

  tx_buffer_config #(.WORDS_PER_BUFFER(WPB)) i_tx_buffer_config (.core_clk(core_clk),
    .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .layout(layout),
    .init_active(init_active), .config_change_enable(config_change_enable));
  apb_master i_apb_master (.core_clk(core_clk), .apb_rsp(apb_rsp), .apb_req(apb_req));

  // -------------------------
  // helpers and model
  // -------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic tx_layout_t exp_layout(logic [31:0] v);
    int n, q;
    n = (v[21:16] > 32) ? 32 : int'(v[21:16]);
    q = (v[29:24] > 32) ? 32 : int'(v[29:24]);
    return '{v[15:2], 6'(n), 6'(q), fifo_queue_mode_t'(v[30]), 14'(int'(v[15:2]) + n * WPB)};
  endfunction

  task automatic cmp(input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // -------------------------
  // clock, watchdog, tests
  // -------------------------
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    m_txbc = TXBC_RESET;
    i_apb_master.xfer(1'b0, TXBC_ADDR, 32'h0000_0000, rd, err);
    cmp({err, rd}, {1'b0, m_txbc});
    for (int i = 0; i < 40; i++) begin
      m_ctrl = (i % 4 == 3) ? (rnd() & 32'h0000_0003) : 32'h0000_0003;
      i_apb_master.xfer(1'b1, CTRL_ADDR, m_ctrl, rd, err);
      @(negedge core_clk);
      cmp({config_change_enable, init_active}, m_ctrl[1:0]);
      d = rnd();
      if (i == 1) d = 32'h7f3f_ffff;
      if (i == 2) d = 32'h2020_0004;
      if (i == 4) d = 32'h4810_0010;
      i_apb_master.xfer(1'b1, TXBC_ADDR, d, rd, err);
      cmp(err, 1'b0);
      if (m_ctrl == 32'h0000_0003) m_txbc = d & TXBC_MASK;
      i_apb_master.xfer(1'b0, TXBC_ADDR, rnd(), rd, err);
      cmp({err, rd}, {1'b0, m_txbc});
      @(posedge core_clk);
      cmp(layout, exp_layout(m_txbc));
    end
    i_apb_master.xfer(1'b0, 32'hf805_4200, 32'h0000_0000, rd, err);
    cmp({err, rd}, {1'b1, 32'h0000_0000});
    end_of_test();
  end
endmodule
